// ### include/vpw_link_pkg.sv
// Constants and types for the link controller host interface.
// Assumes a 32-bit AXI4-Lite master and a symbol layer outside this block.
package vpw_link_pkg;
	localparam logic [7:0] ADDR_STATE_VECTOR = 8'h00;
	localparam logic [7:0] ADDR_LINK_DATA = 8'h04;
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h08;
	localparam logic [7:0] ADDR_CONTROL_TWO = 8'h0c;
	localparam logic [7:0] ADDR_POWER = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam int CTL1_ALLOW_BIT = 0;
	localparam int CTL1_WCM_BIT = 1;
	localparam int CTL2_EOD_BIT = 0;
	localparam int PWR_WAIT_BIT = 0;
	localparam int PWR_STOP_BIT = 1;
	localparam int NUM_FLAGS = 8;
	localparam int FLAG_EOF = 0;
	localparam int FLAG_IFR = 1;
	localparam int FLAG_RXFULL = 2;
	localparam int FLAG_TXEMPTY = 3;
	localparam int FLAG_ARB = 4;
	localparam int FLAG_CRC = 5;
	localparam int FLAG_SYMBOL = 6;
	localparam int FLAG_WAKE = 7;
	localparam logic [7:0] VEC_NONE = 8'h00;
	localparam logic [7:0] VEC_EOF = 8'h04;
	localparam logic [7:0] VEC_IFR = 8'h08;
	localparam logic [7:0] VEC_RXFULL = 8'h0c;
	localparam logic [7:0] VEC_TXEMPTY = 8'h10;
	localparam logic [7:0] VEC_ARB = 8'h14;
	localparam logic [7:0] VEC_CRC = 8'h18;
	localparam logic [7:0] VEC_SYMBOL = 8'h1c;
	localparam logic [7:0] VEC_WAKE = 8'h20;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] EXTRA_ONES = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		MODE_RUN = 4'b0001,
		MODE_WAIT = 4'b0010,
		MODE_STOP = 4'b0100,
		MODE_RESUME = 4'b1000
	} mode_type;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SHIFT = 3'b010,
		TX_TAIL = 3'b100
	} tx_state_type;
endpackage

// ### logic/vpw_link_host_interface.sv
// Host side of a byte-level serial link controller: state vector, data
// buffers, low-power modes. Assumes a symbol layer that gives bit ticks,
// received bits, frame markers and error events, all synchronous to clk_i.
// Functional notes
// - State vector gives a jump-table offset tied to the current controller state.
// - Vector codes: none 00, end of frame 04, response byte 08, rx full 0c.
// - Vector codes: tx empty 10, arbitration lost 14, checksum 18, symbol 1c.
// - Wakeup 20 has top priority; vector shows highest pending source.
// - Clearing a higher source lets the vector show the remaining lower one.
// - Vector read clears shown source, except rx full, response byte, tx empty.
// - Rx full and response byte clear after vector read then data read.
// - Tx empty clears after vector read then data write, or end-of-data set.
// - Data read returns last received byte; read it after rx full.
// - Finished shift register loads the byte waiting in the tx holding buffer.
// - Tx empty sets after first bit of new byte; holding buffer then free.
// - Completed rx byte goes to rx holding buffer and sets rx full, or response byte if IFR.
// - Rx holding buffer is overwritten by next byte; software must keep up.
// - No next byte means underrun: two extra ones, then transmitter stops.
// - Receiver reports an aborted, non-byte-aligned frame as invalid symbol.
// - Wait instruction with wait-clock-mode clear enters wait; bus not driven.
// - In wait, a received message wakes the block and raises an interrupt.
// - Stop instruction, or wait with wait-clock-mode set, enters stop mode.
// - In stop, passive-to-active bus edge wakes and raises a non-maskable interrupt.
// - Via wait, waking byte is kept only if end of frame preceded entry.
// - Stop entered mid-frame wakes on first edge; that message may be lost.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module vpw_link_host_interface
	import vpw_link_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic bit_tick_i,
	input wire logic rx_bit_i,
	input wire logic rx_bit_valid_i,
	input wire logic rx_ifr_i,
	input wire logic rx_eod_i,
	input wire logic rx_eof_i,
	input wire logic arb_lost_i,
	input wire logic crc_error_i,
	input wire logic symbol_error_i,
	input wire logic bus_active_i,
	input wire logic clocks_stable_i,
	output logic tx_bit_o,
	output logic tx_drive_o,
	output logic tx_frame_end_o,
	output logic irq_o,
	output logic nmi_o,
	output logic [3:0] mode_o
);

////////////////////////////////////////////////////////////////////////////////

	logic awready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic [7:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [7:0] raddr_r;
	logic [NUM_FLAGS-1:0] flag_r;
	logic [NUM_FLAGS-1:0] flag_nxt;
	logic [NUM_FLAGS-1:0] flag_set;
	logic [NUM_FLAGS-1:0] flag_clr;
	logic allow_r;
	logic wcm_r;
	logic eod_req_r;
	logic rx_armed_r;
	logic tx_armed_r;
	logic underrun_r;
	mode_type mode_r;
	mode_type mode_nxt;
	tx_state_type tx_state_r;
	tx_state_type tx_state_nxt;
	logic [7:0] tx_hold_r;
	logic tx_hold_full_r;
	logic [7:0] tx_shift_r;
	logic [2:0] tx_cnt_r;
	logic [1:0] tail_cnt_r;
	logic tx_bit_r;
	logic tx_drive_r;
	logic frame_end_r;
	logic [7:0] rx_shift_r;
	logic [2:0] rx_cnt_r;
	logic [7:0] rx_hold_r;
	logic in_frame_r;
	logic eof_seen_r;
	logic keep_r;
	logic discard_r;
	logic bus_prev_r;
	logic irq_r;
	logic nmi_r;
	logic [7:0] vector;
	logic [2:0] vec_idx;

////////////////////////////////////////////////////////////////////////////////
// Bus decode.

	wire wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !awready_r && !bvalid_r;
	wire wr_do = awready_r;
	wire wr_lane0 = wstrb_r[0];
	wire wr_vec = wr_do && waddr_r == ADDR_STATE_VECTOR;
	wire wr_data = wr_do && waddr_r == ADDR_LINK_DATA && wr_lane0;
	wire wr_ctl1 = wr_do && waddr_r == ADDR_CONTROL_ONE && wr_lane0;
	wire wr_ctl2 = wr_do && waddr_r == ADDR_CONTROL_TWO && wr_lane0;
	wire wr_pwr = wr_do && waddr_r == ADDR_POWER && wr_lane0;
	wire wr_stat = wr_do && waddr_r == ADDR_STATUS;
	wire wr_hit = wr_vec || wr_stat || (wr_do && waddr_r == ADDR_LINK_DATA)
		|| (wr_do && waddr_r == ADDR_CONTROL_ONE)
		|| (wr_do && waddr_r == ADDR_CONTROL_TWO)
		|| (wr_do && waddr_r == ADDR_POWER);
	wire rd_go = s_axi_arvalid_i && !arready_r && !rvalid_r;
	wire rd_do = arready_r;
	wire rd_vec = rd_do && raddr_r == ADDR_STATE_VECTOR;
	wire rd_data = rd_do && raddr_r == ADDR_LINK_DATA;
	wire rd_hit = rd_vec || rd_data || (rd_do && raddr_r == ADDR_CONTROL_ONE)
		|| (rd_do && raddr_r == ADDR_CONTROL_TWO)
		|| (rd_do && raddr_r == ADDR_POWER)
		|| (rd_do && raddr_r == ADDR_STATUS);
	wire eod_set = wr_ctl2 && wdata_r[CTL2_EOD_BIT];
	wire wait_cmd = wr_pwr && wdata_r[PWR_WAIT_BIT] && !wdata_r[PWR_STOP_BIT];
	wire stop_cmd = wr_pwr && wdata_r[PWR_STOP_BIT];
	wire [7:0] ctl1_rd = {6'h00, wcm_r, allow_r};
	wire [7:0] ctl2_rd = {7'h00, eod_req_r};
	wire [7:0] stat_rd = {2'h0, discard_r, in_frame_r, tx_hold_full_r,
		underrun_r, mode_r == MODE_RUN, mode_r == MODE_RESUME};
	wire [7:0] rd_byte = rd_vec ? vector
		: rd_data ? rx_hold_r
		: (raddr_r == ADDR_CONTROL_ONE) ? ctl1_rd
		: (raddr_r == ADDR_CONTROL_TWO) ? ctl2_rd
		: (raddr_r == ADDR_STATUS) ? stat_rd
		: BYTE_RESET;

////////////////////////////////////////////////////////////////////////////////
// Vector: the highest pending flag wins, so clearing one exposes the next.

	always_comb
	begin
		vec_idx = 3'h0;
		for (int i = 0; i < NUM_FLAGS; i++)
		begin
			if (flag_r[i])
			begin
				vec_idx = 3'(i);
			end
		end
	end

	wire any_flag = |flag_r;
	// Codes sit four apart so the value indexes a table of four-byte slots.
	assign vector = any_flag ? {2'h0, ({1'b0, vec_idx} + 4'h1), 2'h0}
		: VEC_NONE;
	wire shows_rx = any_flag && (vec_idx == 3'(FLAG_RXFULL) || vec_idx == 3'(FLAG_IFR));
	wire shows_tx = any_flag && vec_idx == 3'(FLAG_TXEMPTY);

////////////////////////////////////////////////////////////////////////////////
// Transmit path.

	wire tx_run = mode_r == MODE_RUN;
	wire tx_tick = bit_tick_i && tx_run;
	wire tx_load_idle = tx_state_r == TX_IDLE && tx_hold_full_r && tx_run;
	wire tx_byte_done = tx_tick && tx_state_r == TX_SHIFT && tx_cnt_r == LAST_BIT;
	wire tx_load_next = tx_byte_done && tx_hold_full_r;
	wire tx_load = tx_load_idle || tx_load_next;
	wire tx_close = tx_byte_done && !tx_hold_full_r && eod_req_r;
	wire tx_underrun = tx_byte_done && !tx_hold_full_r && !eod_req_r;
	wire tail_done = tx_tick && tx_state_r == TX_TAIL && tail_cnt_r == EXTRA_ONES - 2'h1;
	wire first_bit = tx_tick && tx_state_r == TX_SHIFT && tx_cnt_r == 3'h0;

	always_comb
	begin
		tx_state_nxt = tx_state_r;
		case (tx_state_r)
			TX_IDLE:
			begin
				if (tx_load_idle)
				begin
					tx_state_nxt = TX_SHIFT;
				end
			end
			TX_SHIFT:
			begin
				if (tx_close)
				begin
					tx_state_nxt = TX_IDLE;
				end
				else if (tx_underrun)
				begin
					tx_state_nxt = TX_TAIL;
				end
			end
			TX_TAIL:
			begin
				if (tail_done)
				begin
					tx_state_nxt = TX_IDLE;
				end
			end
			default:
			begin
				tx_state_nxt = TX_IDLE;
			end
		endcase
		if (!tx_run)
		begin
			tx_state_nxt = TX_IDLE;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Receive path. Bits are ignored in stop mode because its clocks are halted.

	wire rx_take = rx_bit_valid_i && mode_r != MODE_STOP && mode_r != MODE_RESUME;
	wire rx_byte_done = rx_take && rx_cnt_r == LAST_BIT;
	wire rx_store = rx_byte_done && !discard_r;
	wire rx_partial = rx_eod_i && rx_cnt_r != 3'h0;

////////////////////////////////////////////////////////////////////////////////
// Power modes.

	wire bus_rise = bus_active_i && !bus_prev_r;
	wire stop_wake = mode_r == MODE_STOP && bus_rise;
	wire wait_wake = mode_r == MODE_WAIT && rx_eof_i;

	always_comb
	begin
		mode_nxt = mode_r;
		case (mode_r)
			MODE_RUN:
			begin
				if (stop_cmd || (wait_cmd && wcm_r))
				begin
					mode_nxt = MODE_STOP;
				end
				else if (wait_cmd)
				begin
					mode_nxt = MODE_WAIT;
				end
			end
			MODE_WAIT:
			begin
				if (wait_wake)
				begin
					mode_nxt = MODE_RUN;
				end
			end
			MODE_STOP:
			begin
				if (stop_wake)
				begin
					mode_nxt = MODE_RESUME;
				end
			end
			MODE_RESUME:
			begin
				if (clocks_stable_i)
				begin
					mode_nxt = MODE_RUN;
				end
			end
			default:
			begin
				mode_nxt = MODE_RUN;
			end
		endcase
	end

	wire enter_stop = mode_r == MODE_RUN && mode_nxt == MODE_STOP;
	wire keep_nxt = wait_cmd && !stop_cmd && eof_seen_r && !in_frame_r;

////////////////////////////////////////////////////////////////////////////////
// Flags. A set in the same cycle as its clear wins.

	always_comb
	begin
		flag_set = '0;
		flag_set[FLAG_EOF] = rx_eof_i;
		flag_set[FLAG_IFR] = rx_store && rx_ifr_i;
		flag_set[FLAG_RXFULL] = rx_store && !rx_ifr_i;
		flag_set[FLAG_TXEMPTY] = first_bit && !eod_req_r && !eod_set;
		flag_set[FLAG_ARB] = arb_lost_i;
		flag_set[FLAG_CRC] = crc_error_i;
		flag_set[FLAG_SYMBOL] = symbol_error_i || rx_partial;
		flag_set[FLAG_WAKE] = stop_wake || wait_wake;
		flag_clr = '0;
		if (rd_vec && any_flag && !shows_rx && !shows_tx)
		begin
			flag_clr[vec_idx] = 1'b1;
		end
		flag_clr[FLAG_RXFULL] = rd_data && rx_armed_r;
		flag_clr[FLAG_IFR] = rd_data && rx_armed_r;
		flag_clr[FLAG_TXEMPTY] = (wr_data && tx_armed_r) || eod_set;
		flag_nxt = flag_set | (flag_r & ~flag_clr);
	end

////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			awready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= '0;
			waddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			raddr_r <= '0;
		end
		else
		begin
			awready_r <= wr_go;
			if (wr_go)
			begin
				waddr_r <= s_axi_awaddr_i;
				wdata_r <= s_axi_wdata_i;
				wstrb_r <= s_axi_wstrb_i;
			end
			if (wr_do)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready_i)
			begin
				bvalid_r <= 1'b0;
			end
			arready_r <= rd_go;
			if (rd_go)
			begin
				raddr_r <= s_axi_araddr_i;
			end
			if (rd_do)
			begin
				rvalid_r <= 1'b1;
				rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
				rdata_r <= {24'h000000, rd_byte};
			end
			else if (s_axi_rready_i)
			begin
				rvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			flag_r <= '0;
			allow_r <= 1'b0;
			wcm_r <= 1'b0;
			eod_req_r <= 1'b0;
			rx_armed_r <= 1'b0;
			tx_armed_r <= 1'b0;
			underrun_r <= 1'b0;
			mode_r <= MODE_RUN;
			keep_r <= 1'b0;
			discard_r <= 1'b0;
			bus_prev_r <= 1'b0;
			irq_r <= 1'b0;
			nmi_r <= 1'b0;
		end
		else
		begin
			flag_r <= flag_nxt;
			mode_r <= mode_nxt;
			bus_prev_r <= bus_active_i;
			if (wr_ctl1)
			begin
				allow_r <= wdata_r[CTL1_ALLOW_BIT];
				wcm_r <= wdata_r[CTL1_WCM_BIT];
			end
			if (eod_set)
			begin
				eod_req_r <= 1'b1;
			end
			else if (tx_close || tail_done || !tx_run)
			begin
				eod_req_r <= 1'b0;
			end
			// Arming needs a vector read that showed a data condition first.
			rx_armed_r <= (rd_vec && shows_rx) || (rx_armed_r && !rd_data);
			tx_armed_r <= (rd_vec && shows_tx) || (tx_armed_r && !wr_data);
			underrun_r <= tail_done || (underrun_r && !(wr_stat && wdata_r[0]));
			if (enter_stop)
			begin
				keep_r <= keep_nxt;
			end
			if (stop_wake)
			begin
				discard_r <= !keep_r || in_frame_r;
			end
			else if (rx_eof_i)
			begin
				discard_r <= 1'b0;
			end
			irq_r <= allow_r && |flag_nxt;
			nmi_r <= stop_wake;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			tx_state_r <= TX_IDLE;
			tx_hold_r <= BYTE_RESET;
			tx_hold_full_r <= 1'b0;
			tx_shift_r <= BYTE_RESET;
			tx_cnt_r <= 3'h0;
			tail_cnt_r <= 2'h0;
			tx_bit_r <= 1'b0;
			tx_drive_r <= 1'b0;
			frame_end_r <= 1'b0;
		end
		else
		begin
			tx_state_r <= tx_state_nxt;
			if (wr_data)
			begin
				tx_hold_r <= wdata_r[7:0];
			end
			tx_hold_full_r <= wr_data || (tx_hold_full_r && !tx_load);
			if (tx_load)
			begin
				tx_shift_r <= tx_hold_r;
				tx_cnt_r <= 3'h0;
			end
			else if (tx_tick && tx_state_r == TX_SHIFT)
			begin
				tx_shift_r <= {tx_shift_r[6:0], 1'b0};
				tx_cnt_r <= tx_cnt_r + 3'h1;
			end
			// The tail count must hold between ticks, or the two ones never finish.
			if (tx_state_r != TX_TAIL)
			begin
				tail_cnt_r <= 2'h0;
			end
			else if (tx_tick)
			begin
				tail_cnt_r <= tail_cnt_r + 2'h1;
			end
			if (tx_tick && tx_state_r == TX_SHIFT)
			begin
				tx_bit_r <= tx_shift_r[7];
			end
			else if (tx_tick && tx_state_r == TX_TAIL)
			begin
				tx_bit_r <= 1'b1;
			end
			tx_drive_r <= tx_run && tx_state_nxt != TX_IDLE;
			frame_end_r <= tx_close;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			rx_shift_r <= BYTE_RESET;
			rx_cnt_r <= 3'h0;
			rx_hold_r <= BYTE_RESET;
			in_frame_r <= 1'b0;
			eof_seen_r <= 1'b0;
		end
		else
		begin
			if (rx_take)
			begin
				rx_shift_r <= {rx_shift_r[6:0], rx_bit_i};
				rx_cnt_r <= rx_cnt_r + 3'h1;
			end
			else if (rx_eod_i || rx_eof_i)
			begin
				rx_cnt_r <= 3'h0;
			end
			if (rx_store)
			begin
				rx_hold_r <= {rx_shift_r[6:0], rx_bit_i};
			end
			in_frame_r <= rx_take || (in_frame_r && !rx_eof_i);
			eof_seen_r <= rx_eof_i || (eof_seen_r && !rx_take);
		end
	end

////////////////////////////////////////////////////////////////////////////////

	assign s_axi_awready_o = awready_r;
	assign s_axi_wready_o = awready_r;
	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_arready_o = arready_r;
	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rresp_o = rresp_r;
	assign s_axi_rdata_o = rdata_r;
	assign tx_bit_o = tx_bit_r;
	assign tx_drive_o = tx_drive_r;
	assign tx_frame_end_o = frame_end_r;
	assign irq_o = irq_r;
	assign nmi_o = nmi_r;
	assign mode_o = mode_r;

endmodule

// ### tb/vpw_link_asserts.sv
// Checker for the link host interface: bus handshakes, power modes, wake, shifting.
// Assumes it is bound to the design top and sees only the ports it lists.
`timescale 1ns/1ns
module vpw_link_asserts
	import vpw_link_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic bit_tick_i,
	input wire logic clocks_stable_i,
	input wire logic tx_bit_o,
	input wire logic tx_drive_o,
	input wire logic nmi_o,
	input wire logic [3:0] mode_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////////
	AST_AW_W_TOGETHER: assert property (s_axi_awready_o |-> s_axi_wready_o)
		else $error("address and data not taken together");
	AST_B_AFTER_AW: assert property (s_axi_awready_o |=> s_axi_bvalid_o)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	AST_R_AFTER_AR: assert property (s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data changed while waiting");
	AST_MODE_ONEHOT: assert property ($onehot(mode_o))
		else $error("mode not one-hot");
	AST_QUIET_LOW_POWER: assert property (mode_o == MODE_WAIT || mode_o == MODE_STOP |=> !tx_drive_o)
		else $error("bus driven in low power mode");
	AST_NMI_FROM_STOP: assert property (nmi_o |-> mode_o == MODE_RESUME && $past(mode_o) == MODE_STOP)
		else $error("nmi without stop wake");
	AST_RESUME_DONE: assert property (mode_o == MODE_RESUME && clocks_stable_i |=> mode_o == MODE_RUN)
		else $error("no return to run after clocks settle");
	AST_TX_SHIFT: assert property (tx_drive_o && !bit_tick_i |=> $stable(tx_bit_o) || !tx_drive_o)
		else $error("tx bit moved without tick");
	COV_WRITE: cover property (s_axi_bvalid_o && s_axi_bready_i);
	COV_NMI: cover property (nmi_o);
	COV_WAIT_WAKE: cover property (mode_o == MODE_WAIT ##1 mode_o == MODE_RUN);
endmodule
bind vpw_link_host_interface vpw_link_asserts chk (.clk_i, .nrst_i, .s_axi_awready_o,
	.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arready_o,
	.s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .bit_tick_i, .clocks_stable_i,
	.tx_bit_o, .tx_drive_o, .nmi_o, .mode_o);

// ### tb/vpw_link_peer.sv
// Far-side model: symbol layer events, received bits, bit ticks and capture of sent bits.
// Assumes the bench calls its tasks one at a time, right after a rising edge.
`timescale 1ns/1ns
module vpw_link_peer
(
	input wire logic clk_i,
	input wire logic tx_bit_i,
	input wire logic tx_drive_i,
	output logic bit_tick_o,
	output logic rx_bit_o,
	output logic rx_bit_valid_o,
	output logic rx_ifr_o,
	output logic [4:0] event_o,
	output logic bus_active_o,
	output logic clocks_stable_o
);
	logic [2:0] tick_cnt_r;
	logic tick_d_r;
	logic [15:0] tx_seen;
	initial
	begin
		{tick_cnt_r, bit_tick_o, rx_bit_o, rx_bit_valid_o, rx_ifr_o, tick_d_r} = 8'h00;
		{event_o, bus_active_o, tx_seen} = 22'h0;
		clocks_stable_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// Ticks stand still while nothing is sent, as the real bit timer would.
	always @(posedge clk_i)
	begin
		tick_cnt_r <= tx_drive_i ? tick_cnt_r + 3'h1 : 3'h0;
		bit_tick_o <= tx_drive_i && tick_cnt_r == 3'h7;
		tick_d_r <= bit_tick_o;
		// The sent bit moves on the tick edge, so it is taken one edge later.
		if (tick_d_r)
			tx_seen <= {tx_seen[14:0], tx_bit_i};
	end
	task automatic send_byte(input logic [7:0] b, input logic ifr);
		int i;
		rx_ifr_o <= ifr;
		for (i = 7; i >= 0; i--)
		begin
			@(posedge clk_i);
			rx_bit_o <= b[i];
			rx_bit_valid_o <= 1'b1;
			@(posedge clk_i);
			rx_bit_valid_o <= 1'b0;
			rx_bit_o <= ~b[i];
		end
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge clk_i);
		event_o <= m;
		@(posedge clk_i);
		event_o <= 5'h00;
	endtask
	task automatic bus_edge();
		@(posedge clk_i);
		bus_active_o <= 1'b1;
		@(posedge clk_i);
		bus_active_o <= 1'b0;
	endtask
endmodule

// ### tb/vpw_link_host_interface_tb.sv
// Self-checking bench for the link host interface over AXI4-Lite.
// Assumes the far-side model drives bits and events; one request at a time.
`timescale 1ns/1ns
module vpw_link_host_interface_tb;
	import vpw_link_pkg::*;
	typedef struct packed {logic [4:0] ev; logic ifr; logic [7:0] data; logic [7:0] vec;} row_type;
	logic clk_i, nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
	logic s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic s_axi_rvalid_o, bit_tick_i, rx_bit_i, rx_bit_valid_i, rx_ifr_i, bus_active_i;
	logic clocks_stable_i, tx_bit_o, tx_drive_o, tx_frame_end_o, irq_o, nmi_o;
	logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rdv;
	logic [3:0] s_axi_wstrb_i, mode_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
	logic [4:0] ev;
	int num_errors = 0;
	int checks_done = 0;
	int i;
	logic [7:0] prio [4] = '{VEC_CRC, VEC_ARB, VEC_EOF, VEC_NONE};
	row_type rows [6] = '{'{5'h01, 1'b0, 8'h00, VEC_EOF}, '{5'h02, 1'b0, 8'h00, VEC_ARB},
		'{5'h04, 1'b0, 8'h00, VEC_CRC}, '{5'h08, 1'b0, 8'h00, VEC_SYMBOL},
		'{5'h00, 1'b0, 8'ha7, VEC_RXFULL}, '{5'h00, 1'b1, 8'h5e, VEC_IFR}};
	vpw_link_host_interface DUT (.clk_i, .nrst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.bit_tick_i, .rx_bit_i, .rx_bit_valid_i, .rx_ifr_i, .rx_eod_i(ev[4]), .rx_eof_i(ev[0]),
		.arb_lost_i(ev[1]), .crc_error_i(ev[2]), .symbol_error_i(ev[3]), .bus_active_i,
		.clocks_stable_i, .tx_bit_o, .tx_drive_o, .tx_frame_end_o, .irq_o, .nmi_o, .mode_o);
	vpw_link_peer peer (.clk_i, .tx_bit_i(tx_bit_o), .tx_drive_i(tx_drive_o),
		.bit_tick_o(bit_tick_i), .rx_bit_o(rx_bit_i), .rx_bit_valid_o(rx_bit_valid_i),
		.rx_ifr_o(rx_ifr_i), .event_o(ev), .bus_active_o(bus_active_i),
		.clocks_stable_o(clocks_stable_i));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic sel(input int k);
		case (k)
			0: return s_axi_awready_o;
			1: return s_axi_bvalid_o;
			2: return s_axi_arready_o;
			3: return s_axi_rvalid_o;
			4: return tx_frame_end_o;
			default: return nmi_o;
		endcase
	endfunction
	// Sampling at the falling edge keeps the answer clear of the edge that launches it.
	task automatic wait_for(input int k);
		int n;
		for (n = 0; n < 400; n++)
		begin
			@(negedge clk_i);
			if (sel(k) === 1'b1)
				return;
		end
		num_errors++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		print_verdict();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		wait_for(0);
		@(posedge clk_i);
		{s_axi_awvalid_i, s_axi_wvalid_i} <= 2'h0;
		wait_for(1);
		rsp = s_axi_bresp_o;
		@(posedge clk_i);
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
		wait_for(2);
		@(posedge clk_i);
		s_axi_arvalid_i <= 1'b0;
		wait_for(3);
		{rdv, rsp} = {s_axi_rdata_o, s_axi_rresp_o};
		@(posedge clk_i);
		s_axi_rready_i <= 1'b0;
	endtask
	task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		int n;
		for (n = 0; n < 60; n++)
		begin
			rd(a);
			if ((rdv[7:0] & m) === e)
				break;
		end
		chk(rdv[7:0] & m, e);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial
	begin
		{nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
		{s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i} = 18'h0;
		{s_axi_wdata_i, s_axi_wstrb_i} = {32'h0, 4'hf};
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(negedge clk_i);
		chk(mode_o, MODE_RUN);
		chk(irq_o, 1'b0);
		rd(ADDR_STATE_VECTOR);
		chk(rdv, VEC_NONE);
		wr(8'h1c, 32'h0);
		chk(rsp, RESP_SLVERR);
		rd(8'h1c);
		chk(rsp, RESP_SLVERR);
		chk(rdv, 32'h0);
		for (i = 0; i < 6; i++)
		begin
			if (rows[i].ev !== 5'h00)
				peer.pulse(rows[i].ev);
			else
				peer.send_byte(rows[i].data, rows[i].ifr);
			rd(ADDR_STATE_VECTOR);
			chk(rdv, rows[i].vec);
			if (rows[i].ev === 5'h00)
			begin
				rd(ADDR_LINK_DATA);
				chk(rdv, rows[i].data);
			end
			rd(ADDR_STATE_VECTOR);
			chk(rdv, VEC_NONE);
			$display("row %0d done", i);
		end
		wr(ADDR_CONTROL_ONE, 32'h1);
		peer.pulse(5'h07);
		repeat (2) @(negedge clk_i);
		chk(irq_o, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			rd(ADDR_STATE_VECTOR);
			chk(rdv, prio[i]);
		end
		chk(irq_o, 1'b0);
		peer.send_byte(8'h11, 1'b0);
		peer.send_byte(8'h22, 1'b0);
		poll(ADDR_STATE_VECTOR, 8'hff, VEC_RXFULL);
		rd(ADDR_LINK_DATA);
		chk(rdv, 32'h22);
		$display("priority and overwrite done");
		wr(ADDR_LINK_DATA, 32'ha5);
		poll(ADDR_STATE_VECTOR, 8'hff, VEC_TXEMPTY);
		wr(ADDR_LINK_DATA, 32'h3c);
		poll(ADDR_STATE_VECTOR, 8'hff, VEC_TXEMPTY);
		wr(ADDR_CONTROL_TWO, 32'h1);
		rd(ADDR_STATE_VECTOR);
		chk(rdv, VEC_NONE);
		wait_for(4);
		@(negedge clk_i);
		chk(peer.tx_seen, 16'ha53c);
		wr(ADDR_LINK_DATA, 32'h81);
		poll(ADDR_STATE_VECTOR, 8'hff, VEC_TXEMPTY);
		poll(ADDR_STATUS, 8'h04, 8'h04);
		chk(peer.tx_seen[9:0], {8'h81, 2'h3});
		wr(ADDR_CONTROL_TWO, 32'h1);
		rd(ADDR_STATE_VECTOR);
		chk(rdv, VEC_NONE);
		$display("transmit done");
		wr(ADDR_POWER, 32'h1);
		chk(mode_o, MODE_WAIT);
		peer.pulse(5'h01);
		repeat (2) @(negedge clk_i);
		chk({mode_o, irq_o}, {MODE_RUN, 1'b1});
		rd(ADDR_STATE_VECTOR);
		chk(rdv, VEC_WAKE);
		poll(ADDR_STATE_VECTOR, 8'hff, VEC_NONE);
		wr(ADDR_CONTROL_ONE, 32'h3);
		@(posedge clk_i);
		peer.clocks_stable_o <= 1'b0;
		wr(ADDR_POWER, 32'h1);
		chk(mode_o, MODE_STOP);
		peer.bus_edge();
		wait_for(5);
		chk(mode_o, MODE_RESUME);
		@(posedge clk_i);
		peer.clocks_stable_o <= 1'b1;
		repeat (2) @(negedge clk_i);
		chk(mode_o, MODE_RUN);
		rd(ADDR_STATE_VECTOR);
		chk(rdv, VEC_WAKE);
		poll(ADDR_STATE_VECTOR, 8'hff, VEC_NONE);
		wr(ADDR_CONTROL_ONE, 32'h0);
		wr(ADDR_POWER, 32'h2);
		chk(mode_o, MODE_STOP);
		peer.bus_edge();
		wait_for(5);
		$display("power modes done");
		@(posedge clk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(negedge clk_i);
		chk({mode_o, nmi_o}, {MODE_RUN, 1'b0});
		$display("second reset done");
		print_verdict();
	end
endmodule
